// ===== inc/cie_pkg.sv
`default_nettype none
package cie_pkg;
	////////////////////////////////////////////////////////////////////////
	// widths and instruction word fields
	localparam int INSN_W      = 14;
	localparam int DATA_W      = 8;
	localparam int PC_W        = 13;
	localparam int FADDR_W     = 7;
	localparam int LATCH_W     = 5;
	localparam int JUMP_W      = 11;
	localparam int OPC_MSB     = 13;
	localparam int OPC_LSB     = 8;
	localparam int PFX_LSB     = 11;
	localparam int DEST_BIT    = 7;
	localparam int LATCH_HI    = 4;
	localparam int LATCH_LO    = 3;

	////////////////////////////////////////////////////////////////////////
	// operation codes (top six bits of the word, top three bits for jump)
	localparam logic [5:0] OP_OR_REG = 6'h11;
	localparam logic [5:0] OP_INC    = 6'h12;
	localparam logic [5:0] OP_COPY   = 6'h13;
	localparam logic [5:0] OP_STORE  = 6'h14;
	localparam logic [5:0] OP_OR_IMM = 6'h15;
	localparam logic [2:0] OP_JUMP   = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// register map and reset values
	localparam logic [7:0] REG_LATCH  = 8'h00;
	localparam logic [7:0] REG_ACC    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PC     = 8'h0C;
	localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
	localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
	localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
	localparam logic               ZERO_RST  = 1'b0;

	// file register write port
	typedef struct packed {
		logic               we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0]  wdata;
	} cie_freg_req_s;
endpackage
`default_nettype wire

// ===== rtl/cie_core_exec.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cie_core_exec (
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        insn_valid_i,
	input  wire logic [cie_pkg::INSN_W-1:0]  insn_i,
	output logic                             insn_ready_o,
	input  wire logic [cie_pkg::DATA_W-1:0]  freg_rdata_i,
	output cie_pkg::cie_freg_req_s           freg_req_o,
	output logic [cie_pkg::PC_W-1:0]         pc_o,
	output logic                             pc_load_o,
	output logic [cie_pkg::DATA_W-1:0]       accumulator_o,
	output logic                             zero_flag_o,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [7:0]                  paddr_i,
	input  wire logic [31:0]                 pwdata_i,
	output logic [31:0]                      prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o
);
	import cie_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// sequencing: one instruction cycle is fetch slot plus execute slot
	typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_FLUSH_A, ST_FLUSH_B} cie_state_e;

	cie_state_e             state;
	cie_state_e             next_state;
	logic [INSN_W-1:0]      ir;
	logic [LATCH_W-1:0]     upper_jump_latch;
	logic [5:0]             opc;
	logic                   is_jump;
	logic                   exec;
	logic                   to_file;
	logic                   sets_zero;
	logic                   wr_acc;
	logic                   wr_file;
	logic [DATA_W-1:0]      result;
	logic                   apb_setup;
	logic                   apb_done;
	logic [FADDR_W-1:0]     freg_addr;
	logic                   freg_we;
	logic [DATA_W-1:0]      freg_wdata;

	assign insn_ready_o = (state == ST_FETCH);
	assign exec         = (state == ST_EXEC);
	assign opc          = ir[OPC_MSB:OPC_LSB];
	assign is_jump      = (ir[OPC_MSB:PFX_LSB] == OP_JUMP);
	assign to_file      = ir[DEST_BIT];
	// write port fields packed in struct order: we, addr, wdata
	assign freg_req_o   = {freg_we, freg_addr, freg_wdata};

	// next state: a jump adds a flushed second instruction cycle
	always_comb begin
		next_state = state;
		case (state)
			ST_FETCH: begin
				if (insn_valid_i) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_state = is_jump ? ST_FLUSH_A : ST_FETCH;
			end
			ST_FLUSH_A: next_state = ST_FLUSH_B;
			ST_FLUSH_B: next_state = ST_FETCH;
			default:    next_state = ST_FETCH;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_FETCH;
		end else begin
			state <= next_state;
		end
	end

	// instruction register and file address are taken at acceptance
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ir              <= '0;
			freg_addr       <= '0;
		end else if (insn_ready_o && insn_valid_i) begin
			ir              <= insn_i;
			freg_addr       <= insn_i[FADDR_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execute: result, destination and flag effect per operation
	always_comb begin
		result    = freg_rdata_i;
		sets_zero = 1'b0;
		wr_acc    = 1'b0;
		wr_file   = 1'b0;
		case (opc)
			OP_OR_IMM: begin
				result    = accumulator_o | ir[DATA_W-1:0];
				sets_zero = 1'b1;
				wr_acc    = 1'b1;
			end
			OP_INC: begin
				result    = freg_rdata_i + 8'h01;
				sets_zero = 1'b1;
				wr_acc    = !to_file;
				wr_file   = to_file;
			end
			OP_OR_REG: begin
				result    = accumulator_o | freg_rdata_i;
				sets_zero = 1'b1;
				wr_acc    = !to_file;
				wr_file   = to_file;
			end
			OP_COPY: begin
				result    = freg_rdata_i;
				sets_zero = 1'b1;
				wr_acc    = !to_file;
				wr_file   = to_file;
			end
			OP_STORE: begin
				result    = accumulator_o;
				wr_file   = 1'b1;
			end
			default: begin
				result    = freg_rdata_i; // jump and unknown codes touch no data
			end
		endcase
	end

	// file register write-back, one cycle after the execute slot
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			freg_we    <= 1'b0;
			freg_wdata <= '0;
		end else begin
			freg_we <= exec && wr_file;
			if (exec && wr_file) begin
				freg_wdata <= result;
			end
		end
	end

	// accumulator and zero flag
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			accumulator_o <= ACC_RST;
			zero_flag_o   <= ZERO_RST;
		end else if (exec) begin
			if (wr_acc) begin
				accumulator_o <= result;
			end
			if (sets_zero) begin
				zero_flag_o <= (result == 8'h00);
			end
		end
	end

	// program counter load on a jump
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_o      <= PC_RST;
			pc_load_o <= 1'b0;
		end else begin
			pc_load_o <= exec && is_jump;
			if (exec && is_jump) begin
				pc_o <= {upper_jump_latch[LATCH_HI:LATCH_LO],
					ir[JUMP_W-1:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, answer registered
	assign apb_setup = psel_i && penable_i && !pready_o;
	assign apb_done  = psel_i && penable_i && pready_o;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			pready_o <= apb_setup;
			if (apb_setup) begin
				prdata_o <= '0;
				if (pwrite_i) begin
					pslverr_o <= (paddr_i != REG_LATCH);
				end else begin
					pslverr_o <= 1'b0;
					case (paddr_i)
						REG_LATCH:  prdata_o <= {27'h0, upper_jump_latch};
						REG_ACC:    prdata_o <= {24'h0, accumulator_o};
						REG_STATUS: prdata_o <= {31'h0, zero_flag_o};
						REG_PC:     prdata_o <= {19'h0, pc_o};
						default:    pslverr_o <= 1'b1;
					endcase
				end
			end
		end
	end

	// upper jump latch, written only by software
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			upper_jump_latch <= LATCH_RST;
		end else if (apb_done && pwrite_i && paddr_i == REG_LATCH) begin
			upper_jump_latch <= pwdata_i[LATCH_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_jump_low_bits:
	assert property (exec && is_jump |=> pc_load_o
		&& pc_o[JUMP_W-1:0] == $past(ir[JUMP_W-1:0]))
		else $error("jump low pc bits wrong");
	a_jump_upper_bits:
	assert property (exec && is_jump |=> pc_o[PC_W-1:JUMP_W]
		== $past(upper_jump_latch[LATCH_HI:LATCH_LO]))
		else $error("jump upper pc bits wrong");
	a_jump_two_cycles:
	assert property (exec && is_jump |=> (!insn_ready_o && $stable(zero_flag_o)
		&& $stable(accumulator_o))[*2] ##1 insn_ready_o)
		else $error("jump timing or flags wrong");
	a_or_imm_result:
	assert property (exec && opc == OP_OR_IMM |=> accumulator_o
		== ($past(accumulator_o) | $past(ir[DATA_W-1:0])))
		else $error("or immediate result wrong");
	a_inc_result:
	assert property (exec && opc == OP_INC |=> (to_file ? freg_req_o.wdata
		: accumulator_o) == 8'($past(freg_rdata_i) + 8'h01))
		else $error("increment result wrong");
	a_dest_select:
	assert property (exec && sets_zero && opc != OP_OR_IMM |=>
		($past(to_file) ? (freg_req_o.we && $stable(accumulator_o))
		: (!freg_req_o.we && accumulator_o == $past(result))))
		else $error("destination select wrong");
	a_or_reg_result:
	assert property (exec && opc == OP_OR_REG && !to_file |=> accumulator_o
		== ($past(accumulator_o) | $past(freg_rdata_i)))
		else $error("or register result wrong");
	a_copy_zero_test:
	assert property (exec && opc == OP_COPY |=>
		zero_flag_o == ($past(freg_rdata_i) == 8'h00))
		else $error("copy zero flag wrong");
	a_store_no_flag:
	assert property (exec && opc == OP_STORE |=> freg_req_o.we
		&& freg_req_o.wdata == $past(accumulator_o) && $stable(zero_flag_o))
		else $error("store accumulator wrong");
	a_zero_flag_value:
	assert property (exec && sets_zero |=> zero_flag_o == ($past(result) == 8'h00))
		else $error("zero flag wrong");
	a_single_cycle:
	assert property (exec && !is_jump |=> insn_ready_o)
		else $error("single cycle instruction stalled");

	c_jump_taken:   cover property (exec && is_jump ##3 insn_ready_o);
	c_inc_wraps:    cover property (exec && opc == OP_INC && freg_rdata_i == 8'hFF);
	c_copy_to_self: cover property (exec && opc == OP_COPY && to_file);
	c_latch_write:  cover property (apb_done && pwrite_i && !pslverr_o);
endmodule
`default_nettype wire

// ===== test/core_insn_exec_subset_bench.sv
`timescale 1ns/1ps
`default_nettype none
module core_insn_exec_subset_bench;
	import cie_pkg::*;
	logic                   sys_clk, rst_n, insn_valid, insn_ready;
	logic [INSN_W-1:0]      insn;
	logic                   psel, penable, pwrite, pready, pslverr;
	logic                   pc_load, zero_flag, er;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic [PC_W-1:0]        pc;
	logic [DATA_W-1:0]      acc;
	logic [DATA_W-1:0]      fmem [128];
	cie_freg_req_s          freg_req;
	int                     err_count = 0, comparisons = 0, loads = 0;
	wire logic [DATA_W-1:0] freg_rdata = fmem[freg_req.addr];

	cie_core_exec dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
		.insn_valid_i(insn_valid), .insn_i(insn), .insn_ready_o(insn_ready),
		.freg_rdata_i(freg_rdata), .freg_req_o(freg_req), .pc_o(pc),
		.pc_load_o(pc_load), .accumulator_o(acc), .zero_flag_o(zero_flag),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr));

	////////////////////////////////////////////////////////////////////////
	// clock, file register array and jump pulse counter
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (freg_req.we === 1'b1) fmem[freg_req.addr] <= freg_req.wdata;
		if (pc_load === 1'b1) loads <= loads + 1;
	end

	////////////////////////////////////////////////////////////////////////
	// comparison, register bus and instruction tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// offer one word, then count the cycles the port stays busy
	task run(input logic [INSN_W-1:0] w, input int busy);
		int n;
		@(posedge sys_clk);
		insn_valid <= 1'b1;
		insn <= w;
		do @(posedge sys_clk); while (insn_ready !== 1'b1);
		insn_valid <= 1'b0;
		n = 0;
		@(posedge sys_clk);
		while (insn_ready !== 1'b1) begin
			n++;
			@(posedge sys_clk);
		end
		@(negedge sys_clk);
		check(32'(n), 32'(busy));
	endtask
	task st(input logic [7:0] a, input logic z);
		check(32'(acc), 32'(a));
		check(32'(zero_flag), 32'(z));
	endtask
	task finish_test;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		finish_test;
	end

	////////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		rst_n = 1'b0;
		insn_valid = 1'b0;
		insn = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		for (int i = 0; i < 128; i++) fmem[i] = 8'h00;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			check(rd, 32'h0);
			check(32'(er), 32'h0);
		end
		apb(1'b0, 8'h10, 32'h0);
		check(32'(er), 32'h1);
		apb(1'b1, REG_ACC, 32'h55);
		check(32'(er), 32'h1);
		run({OP_OR_IMM, 8'h00}, 1);
		st(8'h00, 1'b1);
		apb(1'b1, REG_LATCH, 32'h18);
		run({OP_JUMP, 11'h7FF}, 3);
		check(32'(pc), 32'h1FFF);
		check(32'(loads), 32'h1);
		st(8'h00, 1'b1);
		apb(1'b1, REG_LATCH, 32'h0F);
		run({OP_JUMP, 11'h2A5}, 3);
		apb(1'b0, REG_PC, 32'h0);
		check(rd, 32'h0AA5);
		run({OP_STORE, 1'b0, 7'h7F}, 1);
		run({OP_OR_IMM, 8'hA5}, 1);
		st(8'hA5, 1'b0);
		run({OP_STORE, 1'b1, 7'h7F}, 1);
		check(32'(fmem[7'h7F]), 32'hA5);
		st(8'hA5, 1'b0);
		fmem[7'h10] = 8'hFF;
		run({OP_INC, 1'b1, 7'h10}, 1);
		check(32'(fmem[7'h10]), 32'h00);
		st(8'hA5, 1'b1);
		run({OP_INC, 1'b0, 7'h7F}, 1);
		st(8'hA6, 1'b0);
		fmem[7'h20] = 8'h50;
		run({OP_OR_REG, 1'b0, 7'h20}, 1);
		st(8'hF6, 1'b0);
		run({OP_OR_REG, 1'b1, 7'h20}, 1);
		check(32'(fmem[7'h20]), 32'hF6);
		run({OP_COPY, 1'b1, 7'h30}, 1);
		st(8'hF6, 1'b1);
		run({OP_COPY, 1'b0, 7'h7F}, 1);
		st(8'hA5, 1'b0);
		apb(1'b0, REG_ACC, 32'h0);
		check(rd, 32'hA5);
		finish_test;
	end
endmodule
`default_nettype wire
